// File: design/sssp_device.sv
// Purpose: synchronous slave end of the serial port
// Assumes: link clock well below hclk/4, master keeps bit count
// Notes:   port disable resets every flag and both shift paths
`include "sssp_params.svh"
module sssp_device (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              serial_port_enable,
  input  wire logic              sync_mode_select,
  input  wire logic              clock_source_master,
  input  wire logic              single_receive_enable,
  input  wire logic              continuous_receive_enable,
  input  wire logic              transmit_enable,
  input  wire logic              transmit_nine_bit_enable,
  input  wire logic              receive_nine_bit_enable,
  input  wire logic              transmit_ninth_bit,
  input  wire logic              clock_polarity_select,
  input  wire logic              sleep_request,
  input  wire logic              transmit_irq_enable,
  input  wire logic              receive_irq_enable,
  input  wire logic              peripheral_irq_enable,
  input  wire logic              holding_write,
  input  wire logic [7:0]        holding_data,
  input  wire logic              fifo_read,
  output logic      [7:0]        receive_fifo_top,
  output logic                   receive_ninth_bit,
  output logic                   receive_ready_flag,
  output logic                   transmit_ready_flag,
  output logic                   shift_reg_empty,
  output logic                   overrun_flag,
  output logic                   slave_active,
  output logic                   wake_event,
  sssp_link_if.device            link
);
  import sssp_pkg::*;

  sssp_dev_state_t r;
  sssp_dev_state_t next_r;
  logic [1:0]      pins_s;
  logic            ck_s;
  logic            dt_s;
  logic            slave_on;
  logic            rx_dir;
  logic            rx_on;
  logic            tx_on;
  logic            lead;
  logic            trail;
  logic [3:0]      tx_bits;
  logic [3:0]      rx_bits;
  sssp_char_t      word;
  sssp_char_t      shifted;

  // Pins come from the master's domain
  sssp_sync #(.WIDTH(2)) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({link.clock_pin, link.data_pin}),
    .sync_out (pins_s)
  );

  assign ck_s = pins_s[1];
  assign dt_s = pins_s[0];

  always_comb begin
    next_r   = r;
    word     = '0;
    shifted  = {dt_s, r.receive_shift_reg[8:1]};
    slave_on = serial_port_enable & sync_mode_select &
               ~clock_source_master;
    rx_dir   = single_receive_enable | continuous_receive_enable;
    rx_on    = slave_on & continuous_receive_enable;
    tx_on    = slave_on & ~rx_dir & transmit_enable;
    tx_bits  = transmit_nine_bit_enable ? `SSSP_BITS9 : `SSSP_BITS8;
    rx_bits  = receive_nine_bit_enable ? `SSSP_BITS9 : `SSSP_BITS8;
    // Edges seen through the synchroniser lag the pin by two cycles
    lead  = clock_polarity_select ? (r.ck_d & ~ck_s)
                                  : (~r.ck_d & ck_s);
    trail = clock_polarity_select ? (~r.ck_d & ck_s)
                                  : (r.ck_d & ~ck_s);
    next_r.ck_d = ck_s;

    // Transmit path; no clock edge, no shift, asleep or not
    if (tx_on && r.tsr_full) begin
      if (lead && r.tx_cnt < tx_bits) begin
        next_r.dt_out = r.transmit_shift_reg[0];
        next_r.transmit_shift_reg    = {1'b0, r.transmit_shift_reg[8:1]};
        next_r.tx_cnt = r.tx_cnt + 4'h1;
      end else if (trail && r.tx_cnt == tx_bits) begin
        next_r.tsr_full = 1'b0;
        next_r.tx_cnt   = 4'h0;
      end
    end
    if (r.hold_full && !next_r.tsr_full) begin
      next_r.transmit_shift_reg       = {transmit_nine_bit_enable & transmit_ninth_bit,
                          r.hold};
      next_r.tsr_full  = 1'b1;
      next_r.tx_cnt    = 4'h0;
      next_r.hold_full = 1'b0;
    end
    // Write after the move so a new word is dropped only when transmit_enable or serial_port_enable is low
    if (holding_write) begin
      next_r.hold      = holding_data;
      next_r.hold_full = 1'b1;
    end
    if (!transmit_enable) begin
      next_r.hold_full = 1'b0;
      next_r.tsr_full  = 1'b0;
      next_r.tx_cnt    = 4'h0;
    end

    // Receive FIFO pop; entry 0 is always the top
    if (fifo_read && r.fifo_cnt != 2'h0) begin
      next_r.fifo0    = r.fifo1;
      next_r.fifo_cnt = r.fifo_cnt - 2'h1;
    end
    if (!continuous_receive_enable) begin
      next_r.rx_cnt = 4'h0;
      next_r.ovr    = 1'b0;
    end else if (rx_on && !r.ovr && trail) begin
      next_r.receive_shift_reg    = shifted;
      next_r.rx_cnt = r.rx_cnt + 4'h1;
      if (r.rx_cnt + 4'h1 == rx_bits) begin
        next_r.rx_cnt = 4'h0;
        word = receive_nine_bit_enable ? shifted
                                       : {1'b0, shifted[8:1]};
        if (next_r.fifo_cnt == `SSSP_FIFO_DEPTH) begin
          next_r.ovr = 1'b1;
        end else if (next_r.fifo_cnt == 2'h0) begin
          next_r.fifo0    = word;
          next_r.fifo_cnt = 2'h1;
        end else begin
          next_r.fifo1    = word;
          next_r.fifo_cnt = 2'h2;
        end
      end
    end

    // Port disable holds everything in reset
    if (!serial_port_enable) begin
      next_r = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign receive_fifo_top    = r.fifo0[7:0];
  assign receive_ninth_bit   = r.fifo0[8];
  assign receive_ready_flag  = r.fifo_cnt != 2'h0;
  assign transmit_ready_flag = ~r.hold_full;
  assign shift_reg_empty     = ~r.tsr_full;
  assign overrun_flag        = r.ovr;
  assign slave_active        = serial_port_enable & sync_mode_select &
                               ~clock_source_master;
  // Only slave logic exists here, so sleep never stops shifting
  assign wake_event = sleep_request &
                      ((receive_ready_flag & receive_irq_enable) |
                       (transmit_ready_flag & transmit_irq_enable &
                        peripheral_irq_enable));
  assign link.data_dev_o  = r.dt_out;
  assign link.data_dev_oe = tx_on;
endmodule : sssp_device

// File: design/sssp_link_if.sv
// Purpose: clock and data wires between master and slave
// Assumes: only the master drives the clock
// Notes:   undriven data pin floats high as if pulled up
interface sssp_link_if;
  logic clock_pin_o;
  logic clock_pin_oe;
  logic clock_pin;
  logic data_dev_o;
  logic data_dev_oe;
  logic data_mst_o;
  logic data_mst_oe;
  logic data_pin;

  assign clock_pin = clock_pin_oe ? clock_pin_o : 1'b0;
  assign data_pin  = data_dev_oe ? data_dev_o :
                     data_mst_oe ? data_mst_o : 1'b1;

  modport device (input clock_pin, input data_pin,
                  output data_dev_o, output data_dev_oe);
  modport master (input data_pin, output clock_pin_o,
                  output clock_pin_oe, output data_mst_o,
                  output data_mst_oe);
endinterface : sssp_link_if

// File: design/sssp_master.sv
// Purpose: link master that makes the shift clock, steered over AHB-Lite
// Assumes: single transfers of whole words, one slave on the bus
// Notes:   zero wait states; read data registered in address phase
`include "sssp_params.svh"
module sssp_master #(
  parameter int HALF_DEFAULT = `SSSP_HALF_CYCLES
) (
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic                hresp,
  output logic      [31:0]    hrdata,
  sssp_link_if.master         link
);
  import sssp_pkg::*;

  localparam logic [7:0] HALF_RST = 8'(HALF_DEFAULT);

  sssp_mst_state_t r;
  sssp_mst_state_t next_r;
  logic            data_s;
  logic [3:0]      nbits;
  logic            wr_hit;

  if (HALF_DEFAULT < `SSSP_MIN_HALF || HALF_DEFAULT > 255) begin : g_bad
    $error("sssp_master: HALF_DEFAULT out of range");
  end

  // Slave drives data from outside our domain
  sssp_sync #(.WIDTH(1)) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (link.data_pin),
    .sync_out (data_s)
  );

  always_comb begin
    next_r = r;
    nbits  = r.nine ? `SSSP_BITS9 : `SSSP_BITS8;
    wr_hit = r.a_valid & r.a_wr;
    next_r.a_valid = hsel & htrans[1] & hready;
    if (hsel & htrans[1] & hready) begin
      next_r.a_wr   = hwrite;
      next_r.a_addr = haddr[4:0];
      next_r.hrdata = 32'h0000_0000;
      case (haddr[4:0])
        `SSSP_OFS_CTRL:   next_r.hrdata = {28'h0, r.nine, r.pol,
                                           r.dir_rx, 1'b0};
        `SSSP_OFS_TXDATA: next_r.hrdata = {23'h0, r.txd};
        `SSSP_OFS_RXDATA: next_r.hrdata = {23'h0, r.rxd};
        `SSSP_OFS_STATUS: next_r.hrdata = {30'h0, r.done,
                                           r.phase != SSSP_IDLE};
        `SSSP_OFS_DIV:    next_r.hrdata = {24'h0, r.div};
        default:          next_r.hrdata = 32'h0000_0000;
      endcase
    end
    // Sticky done; a fresh finish below beats this clear
    if (wr_hit && r.a_addr == `SSSP_OFS_STATUS && hwdata[`SSSP_STAT_DONE]) begin
      next_r.done = 1'b0;
    end
    if (wr_hit && r.a_addr == `SSSP_OFS_TXDATA) begin
      next_r.txd = hwdata[8:0];
    end
    if (wr_hit && r.a_addr == `SSSP_OFS_DIV && r.phase == SSSP_IDLE &&
        hwdata[7:0] >= 8'(`SSSP_MIN_HALF)) begin
      next_r.div = hwdata[7:0];
    end
    case (r.phase)
      SSSP_IDLE: begin
        next_r.ck    = r.pol;
        next_r.dt_oe = 1'b0;
        if (wr_hit && r.a_addr == `SSSP_OFS_CTRL) begin
          next_r.dir_rx = hwdata[`SSSP_CTRL_RX];
          next_r.pol    = hwdata[`SSSP_CTRL_POL];
          next_r.nine   = hwdata[`SSSP_CTRL_NINE];
          next_r.ck     = hwdata[`SSSP_CTRL_POL];
          if (hwdata[`SSSP_CTRL_GO]) begin
            next_r.phase    = SSSP_LEAD;
            next_r.half_cnt = 8'h00;
            next_r.bit_idx  = 4'h0;
            next_r.ck       = ~hwdata[`SSSP_CTRL_POL];
            next_r.dt_oe    = ~hwdata[`SSSP_CTRL_RX];
            next_r.dt_o     = r.txd[0];
          end
        end
      end
      SSSP_LEAD: begin
        next_r.half_cnt = r.half_cnt + 8'h01;
        if (r.half_cnt == r.div - 8'h01) begin
          next_r.phase    = SSSP_TRAIL;
          next_r.half_cnt = 8'h00;
          next_r.ck       = r.pol;
          if (r.dir_rx) begin
            next_r.rxd = {data_s, r.rxd[8:1]};
          end
        end
      end
      SSSP_TRAIL: begin
        next_r.half_cnt = r.half_cnt + 8'h01;
        if (r.half_cnt == r.div - 8'h01) begin
          next_r.half_cnt = 8'h00;
          if (r.bit_idx + 4'h1 == nbits) begin
            next_r.phase = SSSP_IDLE;
            next_r.done  = 1'b1;
            next_r.dt_oe = 1'b0;
            if (r.dir_rx && !r.nine) begin
              next_r.rxd = {1'b0, r.rxd[8:1]};
            end
          end else begin
            next_r.phase   = SSSP_LEAD;
            next_r.bit_idx = r.bit_idx + 4'h1;
            next_r.ck      = ~r.pol;
            next_r.dt_o    = r.txd[r.bit_idx + 4'h1];
          end
        end
      end
      default: next_r.phase = SSSP_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r     <= '0;
      r.div <= HALF_RST;
    end else begin
      r <= next_r;
    end
  end

  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign hrdata            = r.hrdata;
  assign link.clock_pin_o  = r.ck;
  assign link.clock_pin_oe = 1'b1;
  assign link.data_mst_o   = r.dt_o;
  assign link.data_mst_oe  = r.dt_oe;
endmodule : sssp_master

// File: design/sssp_params.svh
// Purpose: constants of the synchronous slave serial port and its master
// Assumes: 200 MHz hclk, one master per link
// Notes:   included by the package and both ends
`ifndef SSSP_PARAMS_SVH
`define SSSP_PARAMS_SVH
`define SSSP_BITS8          4'h8
`define SSSP_BITS9          4'h9
`define SSSP_FIFO_DEPTH     2'h2
`define SSSP_CLK_PERIOD_NS  5
`define SSSP_LINK_PERIOD_NS 80
`define SSSP_HALF_CYCLES    ((`SSSP_LINK_PERIOD_NS/`SSSP_CLK_PERIOD_NS)/2)
`define SSSP_MIN_HALF       6
`define SSSP_OFS_CTRL       5'h00
`define SSSP_OFS_TXDATA     5'h04
`define SSSP_OFS_RXDATA     5'h08
`define SSSP_OFS_STATUS     5'h0c
`define SSSP_OFS_DIV        5'h10
`define SSSP_CTRL_GO        0
`define SSSP_CTRL_RX        1
`define SSSP_CTRL_POL       2
`define SSSP_CTRL_NINE      3
`define SSSP_STAT_BUSY      0
`define SSSP_STAT_DONE      1
`endif

// File: design/sssp_pkg.sv
// Purpose: shared types of the serial port ends
// Assumes: nothing beyond the params header
// Notes:   state structs of both ends live here
`include "sssp_params.svh"
package sssp_pkg;
  typedef logic [8:0] sssp_char_t;

  typedef enum logic [1:0] {
    SSSP_IDLE  = 2'b00,
    SSSP_LEAD  = 2'b01,
    SSSP_TRAIL = 2'b10
  } sssp_phase_t;

  typedef struct packed {
    sssp_char_t transmit_shift_reg;
    logic       tsr_full;
    logic [3:0] tx_cnt;
    logic [7:0] hold;
    logic       hold_full;
    sssp_char_t receive_shift_reg;
    logic [3:0] rx_cnt;
    sssp_char_t fifo0;
    sssp_char_t fifo1;
    logic [1:0] fifo_cnt;
    logic       ovr;
    logic       ck_d;
    logic       dt_out;
  } sssp_dev_state_t;

  typedef struct packed {
    sssp_phase_t phase;
    logic [7:0]  half_cnt;
    logic [3:0]  bit_idx;
    logic        ck;
    logic        dt_o;
    logic        dt_oe;
    sssp_char_t  txd;
    sssp_char_t  rxd;
    logic        done;
    logic        dir_rx;
    logic        pol;
    logic        nine;
    logic [7:0]  div;
    logic        a_valid;
    logic        a_wr;
    logic [4:0]  a_addr;
    logic [31:0] hrdata;
  } sssp_mst_state_t;
endpackage : sssp_pkg

// File: design/sssp_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are levels from another domain
// Notes:   first stage feeds only the second
module sssp_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sssp_sync_state_t;

  sssp_sync_state_t r;
  sssp_sync_state_t next_r;

  if (WIDTH < 1) begin : g_bad_width
    $error("sssp_sync: WIDTH must be at least 1");
  end

  always_comb begin
    next_r.meta   = async_in;
    next_r.stable = r.meta;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sync_out = r.stable;
endmodule : sssp_sync

// File: verif/sssp_link_sva.sv
// Purpose: wire checks on the link between master and slave ends
// Assumes: both ends share one sssp_link_if in the hclk domain
// Notes:   sees wires only, so clock polarity is not known here
`include "sssp_params.svh"
module sssp_link_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clock_pin_o,
  input wire logic clock_pin_oe,
  input wire logic clock_pin,
  input wire logic data_dev_o,
  input wire logic data_dev_oe,
  input wire logic data_mst_o,
  input wire logic data_mst_oe,
  input wire logic data_pin
);
  logic [7:0] gap_cnt;
  logic [7:0] next_gap_cnt;
  logic       ck_q;

  // Saturates so long idle gaps never wrap into a false short half
  always_comb begin
    next_gap_cnt = (gap_cnt == 8'hff) ? gap_cnt : gap_cnt + 8'h01;
    if (clock_pin != ck_q) begin
      next_gap_cnt = 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_cnt <= 8'hff;
      ck_q    <= 1'b0;
    end else begin
      gap_cnt <= next_gap_cnt;
      ck_q    <= clock_pin;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_oe_held;
    data_mst_oe [*8];
  endsequence

  a_half_min: assert property ((clock_pin != ck_q) |->
    gap_cnt >= `SSSP_MIN_HALF) else $error("clock half too short");
  a_clk_owned: assert property (clock_pin_oe)
    else $error("master released the clock");
  a_clk_resolve: assert property (clock_pin == clock_pin_o)
    else $error("clock pin differs from master drive");
  a_pin_dev_wins: assert property (data_dev_oe |->
    data_pin == data_dev_o) else $error("data pin not device bit");
  a_pin_pullup: assert property (!data_dev_oe && !data_mst_oe |->
    data_pin) else $error("released data pin not high");
  a_no_fight_edge: assert property ($changed(clock_pin) |->
    !(data_dev_oe && data_mst_oe)) else $error("both ends drive data");
  a_dev_waits_sync: assert property ($changed(clock_pin) &&
    data_dev_oe |=> $stable(data_dev_o)) else $error("data moved too soon");
  a_mst_oe_held: assert property ($rose(data_mst_oe) |-> s_oe_held)
    else $error("master data drive dropped early");
endmodule : sssp_link_sva

// File: verif/tb_sync_slave_serial_port.sv
// Purpose: master and slave ends joined over one link, self-checking
// Assumes: zero wait AHB slave, master divider at its default
// Notes:   wire bits captured at trailing edges for order checks
`include "sssp_params.svh"
module tb_sync_slave_serial_port;
  timeunit 1ns;
  timeprecision 100ps;
  import sssp_pkg::*;
  typedef struct packed {
    logic       dir;
    logic       nine;
    logic       pol;
    sssp_char_t d;
  } sssp_row_t;
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic serial_port_enable = 1'b1, sync_mode_select = 1'b1;
  logic clock_source_master = 1'b0, single_receive_enable = 1'b0;
  logic continuous_receive_enable = 1'b0, transmit_enable = 1'b0;
  logic transmit_nine_bit_enable = 1'b0, receive_nine_bit_enable = 1'b0;
  logic transmit_ninth_bit = 1'b0, clock_polarity_select = 1'b0;
  logic sleep_request = 1'b0, transmit_irq_enable = 1'b0;
  logic receive_irq_enable = 1'b0, peripheral_irq_enable = 1'b0;
  logic holding_write = 1'b0, fifo_read = 1'b0;
  logic [7:0] holding_data = 8'h00, receive_fifo_top;
  logic receive_ninth_bit, receive_ready_flag, transmit_ready_flag;
  logic shift_reg_empty, overrun_flag, slave_active, wake_event;
  logic [8:0] cap = 9'h000;
  logic       ck_last = 1'b0;
  int         error_cnt = 0;
  int         tests_run = 0;
  sssp_row_t  rows [6] = '{'{1'b0, 1'b0, 1'b0, 9'h0a5},
    '{1'b1, 1'b0, 1'b0, 9'h03c}, '{1'b0, 1'b1, 1'b1, 9'h1c3},
    '{1'b1, 1'b1, 1'b1, 9'h15a}, '{1'b0, 1'b1, 1'b0, 9'h0f0},
    '{1'b1, 1'b1, 1'b0, 9'h1e1}};

  sssp_link_if link ();
  sssp_master u_sssp_master (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .link);
  sssp_device u_sssp_device (.hclk, .hresetn, .serial_port_enable,
    .sync_mode_select, .clock_source_master, .single_receive_enable,
    .continuous_receive_enable, .transmit_enable, .transmit_nine_bit_enable,
    .receive_nine_bit_enable, .transmit_ninth_bit, .clock_polarity_select,
    .sleep_request, .transmit_irq_enable, .receive_irq_enable,
    .peripheral_irq_enable, .holding_write, .holding_data, .fifo_read,
    .receive_fifo_top, .receive_ninth_bit, .receive_ready_flag,
    .transmit_ready_flag, .shift_reg_empty, .overrun_flag, .slave_active,
    .wake_event, .link);
  sssp_link_sva u_sssp_link_sva (.hclk, .hresetn,
    .clock_pin_o(link.clock_pin_o), .clock_pin_oe(link.clock_pin_oe),
    .clock_pin(link.clock_pin), .data_dev_o(link.data_dev_o),
    .data_dev_oe(link.data_dev_oe), .data_mst_o(link.data_mst_o),
    .data_mst_oe(link.data_mst_oe), .data_pin(link.data_pin));

  always #2.5 hclk = ~hclk;

  // Trailing edge is the move back to the idle level
  always @(posedge hclk) begin
    ck_last <= link.clock_pin;
    if (link.clock_pin !== ck_last && link.clock_pin === clock_polarity_select)
      cap <= {link.data_pin, cap[8:1]};
  end

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : tick

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    haddr  <= {27'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic xfer(input logic rx, input logic nine, input logic pol,
                      input logic [8:0] d, output logic [8:0] rd);
    logic [31:0] r;
    bus(1'b1, `SSSP_OFS_TXDATA, {23'h0, d}, r);
    bus(1'b1, `SSSP_OFS_CTRL, {28'h0, nine, pol, rx, 1'b1}, r);
    do bus(1'b0, `SSSP_OFS_STATUS, 32'h0, r); while (r[1] !== 1'b1);
    bus(1'b1, `SSSP_OFS_STATUS, 32'h2, r);
    bus(1'b0, `SSSP_OFS_RXDATA, 32'h0, r);
    rd = r[8:0];
  endtask : xfer

  task automatic put(input logic [7:0] d);
    @(posedge hclk);
    holding_write <= 1'b1;
    holding_data  <= d;
    @(posedge hclk);
    holding_write <= 1'b0;
  endtask : put

  task automatic pop();
    @(posedge hclk);
    fifo_read <= 1'b1;
    @(posedge hclk);
    fifo_read <= 1'b0;
  endtask : pop

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // Sixteen frames of about a microsecond each
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    logic [8:0] r;
    logic [8:0] m;
    logic [31:0] w;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    tick(1);
    chk({transmit_ready_flag, shift_reg_empty, receive_ready_flag,
         overrun_flag, wake_event}, 9'h018);
    // Divider below the floor is refused, default stays
    bus(1'b1, `SSSP_OFS_DIV, 32'h0000_0003, w);
    bus(1'b0, `SSSP_OFS_DIV, 32'h0000_0000, w);
    chk(w[8:0], 9'(`SSSP_HALF_CYCLES));
    chk({hresp, hreadyout}, 9'h001);
    $display("test reset done");
    @(posedge hclk);
    transmit_enable <= 1'b1;
    foreach (rows[i]) begin
      // Master takes the new idle level first; no false edge at the slave
      bus(1'b1, `SSSP_OFS_CTRL, {28'h0, rows[i].nine, rows[i].pol,
          rows[i].dir, 1'b0}, w);
      tick(4);
      @(posedge hclk);
      continuous_receive_enable <= !rows[i].dir;
      transmit_nine_bit_enable  <= rows[i].nine;
      receive_nine_bit_enable   <= rows[i].nine;
      clock_polarity_select     <= rows[i].pol;
      transmit_ninth_bit        <= rows[i].d[8];
      m = rows[i].nine ? 9'h1ff : 9'h0ff;
      if (rows[i].dir) put(rows[i].d[7:0]);
      xfer(rows[i].dir, rows[i].nine, rows[i].pol, rows[i].d, r);
      tick(4);
      if (rows[i].dir) chk(r & m, rows[i].d & m);
      else begin
        chk(receive_ready_flag, 1'b1);
        chk({receive_ninth_bit, receive_fifo_top} & m, rows[i].d & m);
        pop();
      end
      chk(rows[i].nine ? cap : cap >> 1, rows[i].d & m);
      chk(link.clock_pin, rows[i].pol);
      $display("test row %0d done", i);
    end
    @(posedge hclk);
    continuous_receive_enable <= 1'b0;
    transmit_nine_bit_enable  <= 1'b0;
    sleep_request             <= 1'b1;
    transmit_irq_enable       <= 1'b1;
    peripheral_irq_enable     <= 1'b1;
    put(8'h81);
    tick(2);
    chk(transmit_ready_flag, 1'b1);
    chk(shift_reg_empty, 1'b0);
    put(8'h42);
    tick(2);
    chk(transmit_ready_flag, 1'b0);
    chk(wake_event, 1'b0);
    xfer(1'b1, 1'b0, 1'b0, 9'h000, r);
    tick(4);
    chk(r & 9'h0ff, 9'h081);
    chk(transmit_ready_flag, 1'b1);
    chk(wake_event, 1'b1);
    chk(shift_reg_empty, 1'b0);
    @(posedge hclk);
    peripheral_irq_enable <= 1'b0;
    tick(1);
    chk(wake_event, 1'b0);
    xfer(1'b1, 1'b0, 1'b0, 9'h000, r);
    tick(4);
    chk(r & 9'h0ff, 9'h042);
    chk(shift_reg_empty, 1'b1);
    $display("test queue done");
    @(posedge hclk);
    continuous_receive_enable <= 1'b1;
    receive_nine_bit_enable   <= 1'b0;
    receive_irq_enable        <= 1'b1;
    transmit_irq_enable       <= 1'b0;
    tick(1);
    chk(wake_event, 1'b0);
    for (int k = 1; k < 4; k++) begin
      xfer(1'b0, 1'b0, 1'b0, 9'h011 * 9'(k), r);
      tick(4);
      if (k == 1) chk(wake_event, 1'b1);
    end
    chk(overrun_flag, 1'b1);
    chk(receive_fifo_top, 8'h11);
    pop();
    tick(1);
    chk(receive_fifo_top, 8'h22);
    xfer(1'b0, 1'b0, 1'b0, 9'h044, r);
    tick(4);
    pop();
    tick(1);
    chk(receive_ready_flag, 1'b0);
    chk(overrun_flag, 1'b1);
    @(posedge hclk);
    continuous_receive_enable <= 1'b0;
    tick(2);
    chk(overrun_flag, 1'b0);
    @(posedge hclk);
    continuous_receive_enable <= 1'b1;
    for (int k = 0; k < 3; k++) xfer(1'b0, 1'b0, 1'b0, 9'h055, r);
    tick(4);
    chk(overrun_flag, 1'b1);
    // Port disable alone must clear overrun and the stored words
    @(posedge hclk);
    serial_port_enable <= 1'b0;
    tick(1);
    chk({overrun_flag, receive_ready_flag}, 9'h000);
    @(posedge hclk);
    serial_port_enable        <= 1'b1;
    continuous_receive_enable <= 1'b0;
    $display("test overrun done");
    @(posedge hclk);
    single_receive_enable <= 1'b1;
    tick(1);
    chk(link.data_dev_oe, 1'b0);
    chk(slave_active, 1'b1);
    xfer(1'b0, 1'b0, 1'b0, 9'h0aa, r);
    tick(4);
    chk(receive_ready_flag, 1'b0);
    @(posedge hclk);
    single_receive_enable <= 1'b0;
    tick(1);
    chk(link.data_dev_oe, 1'b1);
    @(posedge hclk);
    clock_source_master <= 1'b1;
    tick(1);
    chk(slave_active, 1'b0);
    $display("test mode done");
    end_of_test();
  end
endmodule : tb_sync_slave_serial_port
